// file: inc/fsc_pkg.sv
// constants for the fault status capture block
package fsc_pkg;

	// register group placement
	localparam logic [31:0] BASE_ADDR = 32'he000ed00;
	localparam logic [31:0] GROUP_MASK = 32'hffffff00;
	localparam logic [7:0] OFF_HARD_FAULT_STATUS = 8'h2c;
	localparam logic [7:0] OFF_MEMORY_FAULT_ADDRESS = 8'h34;
	localparam logic [7:0] OFF_BUS_FAULT_ADDRESS = 8'h38;

	// hard fault status field positions
	localparam int BIT_DEBUG_RESERVED = 31;
	localparam int BIT_ESCALATED = 30;
	localparam int BIT_VECTOR_READ = 1;
	localparam logic [31:0] HFS_IMPL_MASK = 32'hc0000002;

	// reset values
	localparam logic [31:0] HFS_RESET = 32'h00000000;
	localparam logic [31:0] ADDR_RESET = 32'h00000000;
	localparam logic [31:0] PC_RESET = 32'h00000000;
	localparam logic [31:0] READ_IDLE = 32'h00000000;

	// access size encoding
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] WORD_ALIGNED = 2'h0;

	// register port answer
	typedef enum {FSC_ANS_NONE, FSC_ANS_OK, FSC_ANS_ERR} fsc_ans_e;

endpackage

// file: hdl/fsc_top.sv
// fault status and fault address capture with its register port
//
// Behaviour
// - status bits read normally, write one clears
// - status register resets to all zeros
// - escalated configurable fault sets escalated flag
// - vector read bus error sets flag, hard fault
// - vector fault stacks the preempted instruction pc
// - reserved status bits read zero always
// - memory fault address held while valid
// - memory address is actual faulting sub-access
// - bus fault address held while valid
// - bus address is instruction requested address
// - only aligned word accesses to these registers
// - unaligned register accesses are not supported
// - later fault may overwrite address registers
// - group decoded at fixed base, status 0x2c
// - bus valid set on known-address bus fault
// - data violation loads memory address, valid
module fsc_top (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic REG_SEL,
	input wire logic REG_WR,
	input wire logic [31:0] REG_ADDR,
	input wire logic [1:0] REG_SIZE,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	output logic REG_DONE,
	output logic REG_ERR,
	input wire logic ESCALATE_EVT,
	input wire logic DEBUG_EVT,
	input wire logic VECTOR_BUS_ERR,
	input wire logic [31:0] PREEMPT_PC,
	output logic [31:0] STACKED_PC,
	output logic HARD_FAULT_REQ,
	input wire logic DATA_ACCESS_VIOLATION,
	input wire logic [31:0] MEM_FAULT_ADDR,
	input wire logic BUS_FAULT,
	input wire logic BUS_ADDR_KNOWN,
	input wire logic [31:0] BUS_REQ_ADDR,
	input wire logic MEM_VALID_CLR,
	input wire logic BUS_VALID_CLR,
	output logic MEMORY_ADDRESS_VALID,
	output logic BUS_ADDRESS_VALID
);

	////////////////////////////////////////////////////////////////////////
	// storage

	logic [31:0] hard_fault_status_reg;
	logic [31:0] hard_fault_status_next;
	logic [31:0] memory_fault_address_reg;
	logic [31:0] memory_fault_address_next;
	logic [31:0] bus_fault_address_reg;
	logic [31:0] bus_fault_address_next;
	logic mem_valid_reg;
	logic mem_valid_next;
	logic bus_valid_reg;
	logic bus_valid_next;
	logic [31:0] stacked_pc_reg;
	logic [31:0] stacked_pc_next;
	logic hard_fault_reg;
	logic hard_fault_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	fsc_pkg::fsc_ans_e ans_reg;
	fsc_pkg::fsc_ans_e ans_next;

	////////////////////////////////////////////////////////////////////////
	// address decode and access checks

	// the group sits at one fixed base, offset in the low byte
	wire logic in_group = (REG_ADDR & fsc_pkg::GROUP_MASK) == fsc_pkg::BASE_ADDR;
	wire logic [7:0] offset = REG_ADDR[7:0];
	wire logic hit_hfs = in_group && (offset == fsc_pkg::OFF_HARD_FAULT_STATUS);
	wire logic hit_mfa = in_group && (offset == fsc_pkg::OFF_MEMORY_FAULT_ADDRESS);
	wire logic hit_bfa = in_group && (offset == fsc_pkg::OFF_BUS_FAULT_ADDRESS);
	wire logic any_hit = hit_hfs || hit_mfa || hit_bfa;

	// byte, halfword or unaligned accesses are refused here
	wire logic size_word = REG_SIZE == fsc_pkg::SIZE_WORD;
	wire logic aligned = REG_ADDR[1:0] == fsc_pkg::WORD_ALIGNED;
	wire logic acc_ok = REG_SEL && any_hit && size_word && aligned;
	wire logic wr_ok = acc_ok && REG_WR;
	wire logic rd_ok = acc_ok && !REG_WR;

	////////////////////////////////////////////////////////////////////////
	// hard fault status flags

	// hardware set requests, one bit per event
	wire logic [31:0] set_dbg = {31'h0, DEBUG_EVT} << fsc_pkg::BIT_DEBUG_RESERVED;
	wire logic [31:0] set_esc = {31'h0, ESCALATE_EVT} << fsc_pkg::BIT_ESCALATED;
	wire logic [31:0] set_vec = {31'h0, VECTOR_BUS_ERR} << fsc_pkg::BIT_VECTOR_READ;
	wire logic [31:0] hfs_set = set_dbg | set_esc | set_vec;

	// write one clears, write zero leaves the bit alone
	wire logic [31:0] hfs_clr = (wr_ok && hit_hfs) ? REG_WDATA : 32'h0;

	// set applied after clear so a coincident event survives
	assign hard_fault_status_next =
		((hard_fault_status_reg & ~hfs_clr) | hfs_set) & fsc_pkg::HFS_IMPL_MASK;

	// hard fault entry for escalation or vector read error
	assign hard_fault_next = ESCALATE_EVT || VECTOR_BUS_ERR;

	// pc stacked for a vector read fault is the preempted one
	assign stacked_pc_next = VECTOR_BUS_ERR ? PREEMPT_PC : stacked_pc_reg;

	////////////////////////////////////////////////////////////////////////
	// fault address capture

	wire logic mem_cap = DATA_ACCESS_VIOLATION;
	wire logic bus_cap = BUS_FAULT && BUS_ADDR_KNOWN;

	// a fresh fault overwrites whatever was held before
	assign memory_fault_address_next = mem_cap ? MEM_FAULT_ADDR :
		(wr_ok && hit_mfa) ? REG_WDATA : memory_fault_address_reg;
	assign bus_fault_address_next = bus_cap ? BUS_REQ_ADDR :
		(wr_ok && hit_bfa) ? REG_WDATA : bus_fault_address_reg;

	// valid flags: capture wins over any clear in the same cycle
	assign mem_valid_next = mem_cap ? 1'b1 :
		MEM_VALID_CLR ? 1'b0 : mem_valid_reg;
	// a later memory fault invalidates the bus address
	assign bus_valid_next = bus_cap ? 1'b1 :
		(BUS_VALID_CLR || mem_cap) ? 1'b0 : bus_valid_reg;

	////////////////////////////////////////////////////////////////////////
	// register port answer

	// read data chosen from the hit register, zero otherwise
	wire logic [31:0] rd_mux =
		hit_hfs ? hard_fault_status_reg :
		hit_mfa ? memory_fault_address_reg :
		hit_bfa ? bus_fault_address_reg : fsc_pkg::READ_IDLE;
	assign rdata_next = rd_ok ? rd_mux : fsc_pkg::READ_IDLE;

	// every selected cycle is answered on the next edge
	assign ans_next = !REG_SEL ? fsc_pkg::FSC_ANS_NONE :
		acc_ok ? fsc_pkg::FSC_ANS_OK : fsc_pkg::FSC_ANS_ERR;

	////////////////////////////////////////////////////////////////////////
	// flip-flops

	// status flags
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			hard_fault_status_reg <= fsc_pkg::HFS_RESET;
			hard_fault_reg <= 1'b0;
			stacked_pc_reg <= fsc_pkg::PC_RESET;
		end else begin
			hard_fault_status_reg <= hard_fault_status_next;
			hard_fault_reg <= hard_fault_next;
			stacked_pc_reg <= stacked_pc_next;
		end
	end

	// address registers and their valid flags
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			memory_fault_address_reg <= fsc_pkg::ADDR_RESET;
			bus_fault_address_reg <= fsc_pkg::ADDR_RESET;
			mem_valid_reg <= 1'b0;
			bus_valid_reg <= 1'b0;
		end else begin
			memory_fault_address_reg <= memory_fault_address_next;
			bus_fault_address_reg <= bus_fault_address_next;
			mem_valid_reg <= mem_valid_next;
			bus_valid_reg <= bus_valid_next;
		end
	end

	// answer
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_reg <= fsc_pkg::READ_IDLE;
			ans_reg <= fsc_pkg::FSC_ANS_NONE;
		end else begin
			rdata_reg <= rdata_next;
			ans_reg <= ans_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// all outputs come from flip-flops, REG_DONE and REG_ERR decoded from ans_reg
	assign REG_RDATA = rdata_reg;
	assign REG_DONE = ans_reg != fsc_pkg::FSC_ANS_NONE;
	assign REG_ERR = ans_reg == fsc_pkg::FSC_ANS_ERR;
	assign STACKED_PC = stacked_pc_reg;
	assign HARD_FAULT_REQ = hard_fault_reg;
	assign MEMORY_ADDRESS_VALID = mem_valid_reg;
	assign BUS_ADDRESS_VALID = bus_valid_reg;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	// status register starts clear on release of reset
	a_hfs_reset_clear: assert property (
		disable iff (1'b0) $rose(RST_N) |-> hard_fault_status_reg == fsc_pkg::HFS_RESET)
		else $error("status not clear after reset");

	// escalation sets its flag even against a clearing write
	a_escalate_sets: assert property (
		ESCALATE_EVT |=> hard_fault_status_reg[fsc_pkg::BIT_ESCALATED] && HARD_FAULT_REQ)
		else $error("escalation flag missing");

	// vector read error sets flag and requests hard fault
	a_vector_sets: assert property (
		VECTOR_BUS_ERR |=> hard_fault_status_reg[fsc_pkg::BIT_VECTOR_READ] && HARD_FAULT_REQ)
		else $error("vector read flag missing");

	// stacked pc equals the preempted instruction address
	a_vector_stacked_pc: assert property (
		VECTOR_BUS_ERR |=> STACKED_PC == $past(PREEMPT_PC))
		else $error("stacked pc wrong");

	// write one clears a flag that is not set again
	a_write_one_clears: assert property (
		wr_ok && hit_hfs && REG_WDATA[fsc_pkg::BIT_ESCALATED] && !ESCALATE_EVT
		|=> !hard_fault_status_reg[fsc_pkg::BIT_ESCALATED])
		else $error("write one did not clear");

	// write zero keeps a set flag
	a_write_zero_keeps: assert property (
		wr_ok && hit_hfs && !REG_WDATA[fsc_pkg::BIT_VECTOR_READ]
		&& hard_fault_status_reg[fsc_pkg::BIT_VECTOR_READ]
		|=> hard_fault_status_reg[fsc_pkg::BIT_VECTOR_READ])
		else $error("write zero changed a flag");

	// reserved bits never show a one
	a_reserved_zero: assert property (
		(hard_fault_status_reg & ~fsc_pkg::HFS_IMPL_MASK) == 32'h0)
		else $error("reserved status bit set");

	// memory fault address captured and marked valid
	a_mem_capture: assert property (
		DATA_ACCESS_VIOLATION |=> memory_fault_address_reg == $past(MEM_FAULT_ADDR)
		&& MEMORY_ADDRESS_VALID)
		else $error("memory fault address not captured");

	// bus fault address is the requested one, held valid
	a_bus_capture: assert property (
		BUS_FAULT && BUS_ADDR_KNOWN |=> bus_fault_address_reg == $past(BUS_REQ_ADDR)
		&& BUS_ADDRESS_VALID)
		else $error("bus fault address not captured");

	// held address stays put while valid and nothing touches it
	a_bus_hold: assert property (
		BUS_ADDRESS_VALID && !BUS_FAULT && !(wr_ok && hit_bfa)
		|=> $stable(bus_fault_address_reg))
		else $error("bus fault address drifted");

	// refused sizes or alignment answer with error next cycle
	a_bad_access_err: assert property (
		REG_SEL && any_hit && !(size_word && aligned) |=> REG_DONE && REG_ERR
		##1 !REG_ERR || $past(REG_SEL))
		else $error("bad access not refused");

	// status read returns the flags as they stood
	a_status_read: assert property (
		rd_ok && hit_hfs |=> REG_RDATA == $past(hard_fault_status_reg) && !REG_ERR)
		else $error("status read mismatch");

	// hard fault request only follows one of its two causes
	a_hard_fault_quiet: assert property (
		!ESCALATE_EVT && !VECTOR_BUS_ERR |=> !HARD_FAULT_REQ)
		else $error("hard fault request without cause");

	// vector read error survives a clearing write in the same cycle
	a_vector_beats_clear: assert property (
		VECTOR_BUS_ERR && wr_ok && hit_hfs |=> hard_fault_status_reg[fsc_pkg::BIT_VECTOR_READ])
		else $error("clear beat the vector read flag");

	// bus fault with unknown address leaves the held address alone
	a_bus_unknown_keeps: assert property (
		BUS_FAULT && !BUS_ADDR_KNOWN && !(wr_ok && hit_bfa) |=> $stable(bus_fault_address_reg))
		else $error("unknown bus fault changed address");

	// a later memory fault drops the bus address valid flag
	a_mem_drops_bus: assert property (
		mem_cap && !bus_cap |=> !BUS_ADDRESS_VALID)
		else $error("bus valid kept after memory fault");

	// memory valid clear pulse takes effect when no capture competes
	a_mem_valid_clear: assert property (
		MEM_VALID_CLR && !DATA_ACCESS_VIOLATION |=> !MEMORY_ADDRESS_VALID)
		else $error("memory valid not cleared");

	// a refused write never reaches the memory fault address
	a_refused_no_write: assert property (
		REG_SEL && REG_WR && !acc_ok && !DATA_ACCESS_VIOLATION |=> $stable(memory_fault_address_reg))
		else $error("refused write changed address");

	// a refused access returns idle read data
	a_refused_rdata: assert property (
		REG_SEL && !acc_ok |=> REG_RDATA == fsc_pkg::READ_IDLE)
		else $error("refused access returned data");

	cv_escalate_clear: cover property (ESCALATE_EVT ##[1:8] wr_ok && hit_hfs);
	cv_vector_fault: cover property (VECTOR_BUS_ERR ##1 HARD_FAULT_REQ);
	cv_bus_then_mem: cover property (bus_cap ##[1:8] mem_cap ##1 !BUS_ADDRESS_VALID);
	cv_refused: cover property (REG_SEL && any_hit && !aligned);
	cv_debug_flag: cover property (DEBUG_EVT ##1 hard_fault_status_reg[fsc_pkg::BIT_DEBUG_RESERVED]);

endmodule

// file: tb/fsc_fault_src.sv
// fault source model: core fault detection and handler clear pulses
module fsc_fault_src (
	input wire logic clk,
	output logic escalate_evt,
	output logic debug_evt,
	output logic vector_bus_err,
	output logic [31:0] preempt_pc,
	output logic data_access_violation,
	output logic [31:0] mem_fault_addr,
	output logic bus_fault,
	output logic bus_addr_known,
	output logic [31:0] bus_req_addr,
	output logic mem_valid_clr,
	output logic bus_valid_clr
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle state at time zero
	initial begin
		{bus_valid_clr, mem_valid_clr, bus_addr_known, bus_fault} = 4'h0;
		{data_access_violation, vector_bus_err, debug_evt, escalate_evt} = 4'h0;
		{preempt_pc, mem_fault_addr, bus_req_addr} = {3{32'h00000000}};
	end

	// one-cycle pulse of the chosen events; address lines invert once released
	task automatic fire(input logic [7:0] kinds, input logic [31:0] a);
		@(posedge clk) #1;
		{bus_valid_clr, mem_valid_clr, bus_addr_known, bus_fault} = kinds[7:4];
		{data_access_violation, vector_bus_err, debug_evt, escalate_evt} = kinds[3:0];
		{preempt_pc, mem_fault_addr, bus_req_addr} = {3{a}};
		@(posedge clk) #1;
		{bus_valid_clr, mem_valid_clr, bus_addr_known, bus_fault} = 4'h0;
		{data_access_violation, vector_bus_err, debug_evt, escalate_evt} = 4'h0;
		{preempt_pc, mem_fault_addr, bus_req_addr} = {3{~a}};
	endtask
endmodule

// file: tb/fsc_top_test.sv
// self-checking bench for the fault status capture block
module fsc_top_test;
	timeunit 1ns;
	timeprecision 100ps;

	logic SYS_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic REG_SEL = 1'b0;
	logic REG_WR = 1'b0;
	logic [31:0] REG_ADDR = 32'h00000000;
	logic [1:0] REG_SIZE = 2'h0;
	logic [31:0] REG_WDATA = 32'h00000000;
	logic [31:0] REG_RDATA, PREEMPT_PC, STACKED_PC, MEM_FAULT_ADDR, BUS_REQ_ADDR;
	logic REG_DONE, REG_ERR, ESCALATE_EVT, DEBUG_EVT, VECTOR_BUS_ERR, HARD_FAULT_REQ;
	logic DATA_ACCESS_VIOLATION, BUS_FAULT, BUS_ADDR_KNOWN, MEM_VALID_CLR, BUS_VALID_CLR;
	logic MEMORY_ADDRESS_VALID, BUS_ADDRESS_VALID;
	int err_count = 0;
	int check_count = 0;

	// clock
	always #2.5 SYS_CLK = ~SYS_CLK;

	////////////////////////////////////////////////////////////////////////
	fsc_top fsc_top_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_SEL(REG_SEL), .REG_WR(REG_WR),
		.REG_ADDR(REG_ADDR), .REG_SIZE(REG_SIZE), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.REG_DONE(REG_DONE), .REG_ERR(REG_ERR), .ESCALATE_EVT(ESCALATE_EVT), .DEBUG_EVT(DEBUG_EVT),
		.VECTOR_BUS_ERR(VECTOR_BUS_ERR), .PREEMPT_PC(PREEMPT_PC), .STACKED_PC(STACKED_PC),
		.HARD_FAULT_REQ(HARD_FAULT_REQ), .DATA_ACCESS_VIOLATION(DATA_ACCESS_VIOLATION),
		.MEM_FAULT_ADDR(MEM_FAULT_ADDR), .BUS_FAULT(BUS_FAULT), .BUS_ADDR_KNOWN(BUS_ADDR_KNOWN),
		.BUS_REQ_ADDR(BUS_REQ_ADDR), .MEM_VALID_CLR(MEM_VALID_CLR), .BUS_VALID_CLR(BUS_VALID_CLR),
		.MEMORY_ADDRESS_VALID(MEMORY_ADDRESS_VALID), .BUS_ADDRESS_VALID(BUS_ADDRESS_VALID));
	fsc_fault_src fsc_fault_src_i (.clk(SYS_CLK), .escalate_evt(ESCALATE_EVT), .debug_evt(DEBUG_EVT),
		.vector_bus_err(VECTOR_BUS_ERR), .preempt_pc(PREEMPT_PC),
		.data_access_violation(DATA_ACCESS_VIOLATION), .mem_fault_addr(MEM_FAULT_ADDR),
		.bus_fault(BUS_FAULT), .bus_addr_known(BUS_ADDR_KNOWN), .bus_req_addr(BUS_REQ_ADDR),
		.mem_valid_clr(MEM_VALID_CLR), .bus_valid_clr(BUS_VALID_CLR));

	////////////////////////////////////////////////////////////////////////
	// one register access; the answer already stands when the task returns
	task automatic acc(input logic wr, input logic [7:0] off, input logic [1:0] size, input logic [31:0] wd);
		@(posedge SYS_CLK) #1;
		{REG_SEL, REG_WR, REG_SIZE, REG_WDATA} = {1'b1, wr, size, wd};
		REG_ADDR = fsc_pkg::BASE_ADDR | {24'h000000, off};
		@(posedge SYS_CLK) #1;
		{REG_SEL, REG_WR, REG_WDATA} = {1'b0, 1'b0, ~wd};
		REG_ADDR = ~REG_ADDR;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] off, input logic [31:0] wd);
		acc(1'b1, off, fsc_pkg::SIZE_WORD, wd);
		chk(32'({REG_DONE, REG_ERR}), 32'h00000002);
	endtask

	task automatic rd(input logic [7:0] off, input logic [31:0] exp);
		acc(1'b0, off, fsc_pkg::SIZE_WORD, 32'h00000000);
		chk(32'({REG_DONE, REG_ERR}), 32'h00000002);
		chk(REG_RDATA, exp);
	endtask

	task automatic bad(input logic w, input logic [7:0] off, input logic [1:0] size);
		acc(w, off, size, 32'h0badf00c);
		chk(32'({REG_DONE, REG_ERR}), 32'h00000003);
		chk(REG_RDATA, 32'h00000000);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// watchdog
	initial begin
		#20000;
		err_count++;
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (16) @(posedge SYS_CLK);
		#1 RST_N = 1'b1;
		rd(8'h2c, 32'h00000000);
		rd(8'h34, 32'h00000000);
		fsc_fault_src_i.fire(8'h01, 32'h00000000);
		chk(32'(HARD_FAULT_REQ), 32'h00000001);
		rd(8'h2c, 32'h40000000);
		fsc_fault_src_i.fire(8'h04, 32'h08001234);
		chk(STACKED_PC, 32'h08001234);
		chk(32'(HARD_FAULT_REQ), 32'h00000001);
		rd(8'h2c, 32'h40000002);
		wr(8'h2c, 32'h40000000);
		rd(8'h2c, 32'h00000002);
		fork
			wr(8'h2c, 32'h00000002);
			fsc_fault_src_i.fire(8'h04, 32'h08004000);
		join
		rd(8'h2c, 32'h00000002);
		wr(8'h2c, 32'h00000002);
		rd(8'h2c, 32'h00000000);
		fsc_fault_src_i.fire(8'h30, 32'h20000103);
		rd(8'h38, 32'h20000103);
		chk(32'(BUS_ADDRESS_VALID), 32'h00000001);
		fsc_fault_src_i.fire(8'h10, 32'h20000200);
		rd(8'h38, 32'h20000103);
		fsc_fault_src_i.fire(8'h08, 32'h20000105);
		chk(32'({MEMORY_ADDRESS_VALID, BUS_ADDRESS_VALID}), 32'h00000002);
		rd(8'h34, 32'h20000105);
		fsc_fault_src_i.fire(8'h08, 32'h20000307);
		rd(8'h34, 32'h20000307);
		fsc_fault_src_i.fire(8'h40, 32'h00000000);
		chk(32'(MEMORY_ADDRESS_VALID), 32'h00000000);
		wr(8'h38, 32'h12345678);
		rd(8'h38, 32'h12345678);
		bad(1'b1, 8'h36, fsc_pkg::SIZE_WORD);
		bad(1'b1, 8'h34, fsc_pkg::SIZE_HALF);
		bad(1'b0, 8'h2c, fsc_pkg::SIZE_BYTE);
		bad(1'b0, 8'h30, fsc_pkg::SIZE_WORD);
		rd(8'h34, 32'h20000307);
		fsc_fault_src_i.fire(8'h02, 32'h00000000);
		rd(8'h2c, 32'h80000000);
		@(posedge SYS_CLK) #1 RST_N = 1'b0;
		repeat (16) @(posedge SYS_CLK);
		#1 RST_N = 1'b1;
		rd(8'h2c, 32'h00000000);
		stop_test();
	end
endmodule
